// ---- pkg/est_consts.svh ----
`ifndef EST_CONSTS_SVH
`define EST_CONSTS_SVH

`define EST_ADDR_W 8
`define EST_DATA_W 32

// register offsets
`define EST_OFF_CTRL 8'h00
`define EST_OFF_CMD 8'h04
`define EST_OFF_EXPOSURE 8'h08
`define EST_OFF_PERIOD 8'h0C
`define EST_OFF_MIN_PERIOD 8'h10
`define EST_OFF_TIMER_DELAY 8'h14
`define EST_OFF_TIMER_DUR 8'h18
`define EST_OFF_READOUT 8'h1C
`define EST_OFF_STATUS 8'h20

// control fields
`define EST_CTRL_MODE 0
`define EST_CTRL_SRC 3:1
`define EST_CTRL_EDGE 5:4
`define EST_CTRL_WIDTH 6
`define EST_CTRL_TLEVEL 7
`define EST_CTRL_USEROUT 8

// command bits
`define EST_CMD_START 0
`define EST_CMD_STOP 1
`define EST_CMD_SWTRIG 2

// encodings
`define EST_SRC_SOFTWARE 3'h0
`define EST_SRC_USEROUT 3'h1
`define EST_SRC_GRABBER 3'h2
`define EST_SRC_TIMER 3'h3
`define EST_SRC_LINE 3'h4
`define EST_EDGE_RISE 2'h0
`define EST_EDGE_FALL 2'h1
`define EST_EDGE_BOTH 2'h2

// reset values, in clock cycles
`define EST_RST_EXPOSURE 32'h0000_2710
`define EST_RST_PERIOD 32'h0001_E848
`define EST_RST_MIN_PERIOD 32'h0000_4E20
`define EST_RST_READOUT 32'h0000_03E8

`endif

// ---- pkg/est_pkg.sv ----
`include "est_consts.svh"

package est_pkg;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_WAIT,
        ST_EXPOSE,
        ST_READOUT
    } est_fsm_e;

    typedef logic [`EST_DATA_W-1:0] est_word_t;

    typedef struct packed {
        logic [`EST_ADDR_W-1:0] addr;
        est_word_t wdata;
        logic wr;
        logic rd;
    } est_bus_req_s;

    typedef struct packed {
        est_fsm_e fsm;
        logic acq;
        logic stopPend;
        logic modeOn;
        logic [2:0] src;
        logic [1:0] edgeSel;
        logic widthMode;
        logic timerLevel;
        logic userOut;
        logic userPrev;
        est_word_t expTime;
        est_word_t period;
        est_word_t minPeriod;
        est_word_t tDelay;
        est_word_t tDuration;
        est_word_t readout;
        est_word_t cnt;
        est_word_t runCnt;
        est_word_t delayCnt;
        logic delayArmed;
        logic followLevel;
        logic [2:0] frameSrc;
        logic frameStart;
        est_word_t rdata;
        logic [1:0] sync1;
        logic [1:0] sync2;
        logic [1:0] sync3;
        logic [1:0] filt;
        logic [1:0] filtPrev;
    } est_state_s;

endpackage : est_pkg

// ---- rtl/est_trigger_ctrl.sv ----
`timescale 1ns/1ps
`include "est_consts.svh"
// Operation
// - the exposure start trigger is the only trigger and begins each frame
// - trigger mode off: generate triggers internally from start until stop
// - free-run rate is programmed rate, clamped to maximum allowed rate
// - trigger mode off: exposure lasts the programmed exposure time
// - trigger mode on: frames start only on triggers from chosen source
// - each software trigger command issued while waiting delivers one exposure start trigger, unless a stop is in the same write (the stop wins)
// - user output source: toggling the software output bit is the trigger
// - edge select picks rising, falling or both edges of the trigger signal
// - software source: exposure lasts the programmed exposure time
// - grabber or line source: timed uses exposure time, width follows signal unless both edges are selected
// - timer width mode: edge timer uses duration, level timer follows line
// - user output width mode: exposure spans output bit on to off (off to on for falling edge, timed for both)
// - timer source delays the external line event by the timer delay
// - line source: external trigger line is the exposure start trigger
// - while waiting, the selected hardware edge starts a frame
// - leave waiting on exposure start, return once a trigger is acceptable
// - software triggers while not ready are discarded
// - grabber line triggers during a running exposure are discarded
// - stop lets a frame in progress finish, else stops at once
// - triggers from any source outside the waiting state are ignored; a free-run trigger falling due during a frame is held until waiting

module est_trigger_ctrl (
    input wire logic clk,
    input wire logic resetn,
    input wire logic clkEn,
    input wire est_pkg::est_bus_req_s busReq,
    output logic [`EST_DATA_W-1:0] busRdata,
    input wire logic externalTriggerLine,
    input wire logic grabberTriggerLine,
    output logic exposureActive,
    output logic frameStartPulse,
    output logic waitingForTrigger,
    output logic acquisitionActive
);
    import est_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    localparam int EXT = 0;
    localparam int GRB = 1;

    localparam est_state_s RESET_STATE = '{
        fsm: ST_IDLE,
        expTime: `EST_RST_EXPOSURE,
        period: `EST_RST_PERIOD,
        minPeriod: `EST_RST_MIN_PERIOD,
        readout: `EST_RST_READOUT,
        default: '0
    };

    est_state_s q;
    est_state_s n;

    function automatic logic edgeHit(input logic r, input logic f,
                                     input logic [1:0] sel);
        logic hit;
        hit = 1'b0;
        case (sel)
            `EST_EDGE_RISE: hit = r;
            `EST_EDGE_FALL: hit = f;
            `EST_EDGE_BOTH: hit = r | f;
            default: hit = 1'b0;
        endcase
        return hit;
    endfunction : edgeHit

    ////////////////////////////////////////////////////////////////////////
    logic [1:0] pinRise;
    logic [1:0] pinFall;
    logic userRise;
    logic userFall;
    logic wrCtrl;
    logic cmdStart;
    logic cmdStop;
    logic cmdSw;
    logic trig;
    logic lineEdge;
    logic levelNow;
    logic activeNow;
    est_word_t effPeriod;

    always_comb begin
        n = q;
        n.frameStart = 1'b0;
        n.rdata = '0;
        trig = 1'b0;
        levelNow = 1'b0;

        // first stage feeds only the second one
        n.sync1 = {grabberTriggerLine, externalTriggerLine};
        n.sync2 = q.sync1;
        n.sync3 = q.sync2;
        for (int i = 0; i < 2; i++) begin
            if (q.sync2[i] == q.sync3[i]) begin
                n.filt[i] = q.sync3[i];
            end
        end
        n.filtPrev = q.filt;
        pinRise = q.filt & ~q.filtPrev;
        pinFall = ~q.filt & q.filtPrev;
        userRise = q.userOut & ~q.userPrev;
        userFall = ~q.userOut & q.userPrev;
        n.userPrev = q.userOut;
        lineEdge = edgeHit(pinRise[EXT], pinFall[EXT], q.edgeSel);

        // register bus
        wrCtrl = busReq.wr && busReq.addr == `EST_OFF_CTRL;
        cmdStart = busReq.wr && busReq.addr == `EST_OFF_CMD
                   && busReq.wdata[`EST_CMD_START];
        cmdStop = busReq.wr && busReq.addr == `EST_OFF_CMD
                  && busReq.wdata[`EST_CMD_STOP];
        cmdSw = busReq.wr && busReq.addr == `EST_OFF_CMD
                && busReq.wdata[`EST_CMD_SWTRIG];
        if (wrCtrl) begin
            n.modeOn = busReq.wdata[`EST_CTRL_MODE];
            n.src = busReq.wdata[`EST_CTRL_SRC];
            n.edgeSel = busReq.wdata[`EST_CTRL_EDGE];
            n.widthMode = busReq.wdata[`EST_CTRL_WIDTH];
            n.timerLevel = busReq.wdata[`EST_CTRL_TLEVEL];
            n.userOut = busReq.wdata[`EST_CTRL_USEROUT];
        end
        if (busReq.wr) begin
            case (busReq.addr)
                `EST_OFF_EXPOSURE: n.expTime = busReq.wdata;
                `EST_OFF_PERIOD: n.period = busReq.wdata;
                `EST_OFF_MIN_PERIOD: n.minPeriod = busReq.wdata;
                `EST_OFF_TIMER_DELAY: n.tDelay = busReq.wdata;
                `EST_OFF_TIMER_DUR: n.tDuration = busReq.wdata;
                `EST_OFF_READOUT: n.readout = busReq.wdata;
                default: ;
            endcase
        end
        if (busReq.rd) begin
            case (busReq.addr)
                `EST_OFF_CTRL: begin
                    n.rdata[`EST_CTRL_MODE] = q.modeOn;
                    n.rdata[`EST_CTRL_SRC] = q.src;
                    n.rdata[`EST_CTRL_EDGE] = q.edgeSel;
                    n.rdata[`EST_CTRL_WIDTH] = q.widthMode;
                    n.rdata[`EST_CTRL_TLEVEL] = q.timerLevel;
                    n.rdata[`EST_CTRL_USEROUT] = q.userOut;
                end
                `EST_OFF_EXPOSURE: n.rdata = q.expTime;
                `EST_OFF_PERIOD: n.rdata = q.period;
                `EST_OFF_MIN_PERIOD: n.rdata = q.minPeriod;
                `EST_OFF_TIMER_DELAY: n.rdata = q.tDelay;
                `EST_OFF_TIMER_DUR: n.rdata = q.tDuration;
                `EST_OFF_READOUT: n.rdata = q.readout;
                `EST_OFF_STATUS: n.rdata[4:0] = {
                    q.stopPend, q.fsm == ST_READOUT,
                    q.fsm == ST_EXPOSE, q.fsm == ST_WAIT, q.acq};
                default: n.rdata = '0;
            endcase
        end

        // free-run clamp: a period shorter than allowed is stretched
        effPeriod = (q.period < q.minPeriod) ? q.minPeriod
                                             : q.period;
        if (q.acq && !q.modeOn && q.runCnt != '0) begin
            n.runCnt = q.runCnt - 32'h1;
        end

        // delay line for the timer source, armed only while waiting
        if (q.delayArmed) begin
            if (q.delayCnt != '0) begin
                n.delayCnt = q.delayCnt - 32'h1;
            end else begin
                n.delayArmed = 1'b0;
            end
        end else if (q.modeOn && q.src == `EST_SRC_TIMER
                     && q.fsm == ST_WAIT && lineEdge) begin
            n.delayArmed = 1'b1;
            n.delayCnt = q.tDelay;
        end

        // trigger selection
        if (!q.modeOn) begin
            trig = q.runCnt == '0;
        end else begin
            case (q.src)
                `EST_SRC_SOFTWARE: trig = cmdSw;
                `EST_SRC_USEROUT: begin
                    trig = edgeHit(userRise, userFall, q.edgeSel);
                end
                `EST_SRC_GRABBER: begin
                    trig = edgeHit(pinRise[GRB], pinFall[GRB],
                                   q.edgeSel);
                end
                `EST_SRC_TIMER: begin
                    trig = q.delayArmed && q.delayCnt == '0;
                end
                `EST_SRC_LINE: trig = lineEdge;
                default: trig = 1'b0;
            endcase
        end

        // level of the signal that a width exposure follows
        case (q.frameSrc)
            `EST_SRC_USEROUT: levelNow = q.userOut;
            `EST_SRC_GRABBER: levelNow = q.filt[GRB];
            default: levelNow = q.filt[EXT];
        endcase
        activeNow = (q.edgeSel == `EST_EDGE_FALL) ? ~levelNow : levelNow;

        ////////////////////////////////////////////////////////////////////
        case (q.fsm)
            ST_IDLE: begin
                // a start during a frame still draining is ignored
                if (cmdStart) begin
                    n.fsm = ST_WAIT;
                    n.acq = 1'b1;
                    n.stopPend = 1'b0;
                    n.runCnt = '0;
                end
            end
            ST_WAIT: begin
                if (q.stopPend || cmdStop) begin
                    n.fsm = ST_IDLE;
                    n.acq = 1'b0;
                    n.stopPend = 1'b0;
                    n.delayArmed = 1'b0;
                end else if (trig) begin
                    n.fsm = ST_EXPOSE;
                    n.frameStart = 1'b1;
                    n.frameSrc = q.src;
                    n.delayArmed = 1'b0;
                    n.runCnt = effPeriod - 32'h1;
                    n.cnt = q.expTime;
                    // both-edge width has no end edge, so it runs timed, except the level timer, which follows the line
                    n.followLevel = q.modeOn && q.widthMode
                        && q.src != `EST_SRC_SOFTWARE
                        && q.edgeSel != `EST_EDGE_BOTH;
                    if (q.modeOn && q.widthMode
                        && q.src == `EST_SRC_TIMER) begin
                        n.followLevel = q.timerLevel;
                        if (!q.timerLevel) begin
                            n.cnt = q.tDuration;
                        end
                    end
                end
            end
            ST_EXPOSE: begin
                // triggers here fall through unused
                if (cmdStop) begin
                    n.stopPend = 1'b1;
                end
                n.cnt = q.cnt - 32'h1;
                if (q.followLevel ? !activeNow
                                  : q.cnt <= 32'h1) begin
                    n.fsm = ST_READOUT;
                    n.cnt = q.readout;
                end
            end
            ST_READOUT: begin
                n.cnt = q.cnt - 32'h1;
                if (q.cnt <= 32'h1) begin
                    if (q.stopPend || cmdStop) begin
                        n.fsm = ST_IDLE;
                        n.acq = 1'b0;
                        n.stopPend = 1'b0;
                    end else begin
                        n.fsm = ST_WAIT;
                    end
                end else if (cmdStop) begin
                    n.stopPend = 1'b1;
                end
            end
            default: n.fsm = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            q <= RESET_STATE;
        end else if (clkEn) begin
            q <= n;
        end
    end

    assign busRdata = q.rdata;
    assign exposureActive = q.fsm == ST_EXPOSE;
    assign frameStartPulse = q.frameStart;
    assign waitingForTrigger = q.fsm == ST_WAIT;
    assign acquisitionActive = q.acq;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    sequence swFire;
        clkEn && q.fsm == ST_WAIT && q.modeOn && !q.stopPend
        && q.src == `EST_SRC_SOFTWARE && cmdSw && !cmdStop;
    endsequence

    sequence stopInWait;
        clkEn && q.fsm == ST_WAIT && cmdStop;
    endsequence

    a_start_from_wait: assert property (
        frameStartPulse && $past(clkEn) |-> $past(q.fsm) == ST_WAIT)
        else $error("frame started outside waiting state");

    a_start_exposes: assert property (
        frameStartPulse |-> exposureActive && !waitingForTrigger)
        else $error("frame start without exposure");

    a_sw_one_frame: assert property (
        swFire |=> frameStartPulse ##0 exposureActive)
        else $error("software trigger lost while waiting");

    a_sw_busy_drop: assert property (
        clkEn && q.fsm != ST_WAIT |=> !frameStartPulse)
        else $error("trigger accepted while busy");

    a_stop_at_once: assert property (
        stopInWait |=> !acquisitionActive && !waitingForTrigger)
        else $error("stop while waiting not immediate");

    a_stop_drain: assert property (
        clkEn && q.fsm == ST_EXPOSE && cmdStop |=> acquisitionActive)
        else $error("frame in progress cut by stop");

    a_timed_len: assert property (
        clkEn && q.fsm == ST_EXPOSE && !q.followLevel && q.cnt > 32'h1
        |=> exposureActive)
        else $error("timed exposure ended early");

    a_width_end: assert property (
        clkEn && q.fsm == ST_EXPOSE && q.followLevel && !activeNow
        |=> !exposureActive)
        else $error("width exposure outlived trigger");

    a_free_run: assert property (
        clkEn && q.fsm == ST_WAIT && !q.modeOn && !q.stopPend
        && q.runCnt == '0 && !cmdStop |=> frameStartPulse)
        else $error("free-run trigger missing");

    a_clamp_rate: assert property (
        frameStartPulse && $past(clkEn)
        |-> q.runCnt >= $past(q.minPeriod) - 32'h1)
        else $error("free-run faster than allowed");

endmodule : est_trigger_ctrl

// ---- verification/est_trigger_source.sv ----
`timescale 1ns/1ps
module est_trigger_source (
    input wire logic clk,
    output logic extLine,
    output logic grabLine
);
    ////////////////////////////////////////////////////////////////////////
    // both lines are push-pull, so they always show a driven level
    initial begin
        extLine = 1'h0;
        grabLine = 1'h0;
    end
    ////////////////////////////////////////////////////////////////////////
    // levels move only just after an edge
    task automatic setExt(input logic v);
        @(posedge clk);
        extLine <= v;
    endtask : setExt
    // one pulse for each wanted frame
    task automatic pulseGrab(input int hi);
        @(posedge clk);
        grabLine <= 1'h1;
        repeat (hi) @(posedge clk);
        grabLine <= 1'h0;
    endtask : pulseGrab
    // equal high and low halves for both-edge use
    task automatic squareExt(input int half, input int n);
        repeat (n) begin
            setExt(1'h1);
            repeat (half - 1) @(posedge clk);
            setExt(1'h0);
            repeat (half - 1) @(posedge clk);
        end
    endtask : squareExt
endmodule : est_trigger_source

// ---- verification/est_trigger_ctrl_test.sv ----
`timescale 1ns/1ps
`include "est_consts.svh"
module est_trigger_ctrl_test;
    import est_pkg::*;
    logic clk;
    logic resetn;
    logic clkEn;
    est_bus_req_s busReq;
    logic [31:0] busRdata;
    logic extLine;
    logic grabLine;
    logic exposureActive;
    logic frameStartPulse;
    logic waitingForTrigger;
    logic acquisitionActive;
    int err_total = 0;
    int checks_done = 0;
    int starts = 0;
    int n;
    int l0;
    int l1;
    est_trigger_ctrl u_est_trigger_ctrl (.clk(clk), .resetn(resetn),
        .clkEn(clkEn), .busReq(busReq), .busRdata(busRdata),
        .externalTriggerLine(extLine), .grabberTriggerLine(grabLine),
        .exposureActive(exposureActive), .frameStartPulse(frameStartPulse),
        .waitingForTrigger(waitingForTrigger),
        .acquisitionActive(acquisitionActive));
    est_trigger_source u_est_trigger_source (.clk(clk), .extLine(extLine),
        .grabLine(grabLine));
    initial begin
        clk = 1'h0;
        forever #4 clk = ~clk;
    end
    // frame starts counted at the edge, ahead of the flop updates
    always @(posedge clk) begin
        if (frameStartPulse === 1'h1) begin
            starts++;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : tally_and_finish
    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL %s expected %0h seen %0h", what, exp, got);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        busReq <= '{addr: a, wdata: d, wr: 1'h1, rd: 1'h0};
        @(posedge clk);
        busReq.wr <= 1'h0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        busReq <= '{addr: a, wdata: 32'h0, wr: 1'h0, rd: 1'h1};
        @(posedge clk);
        busReq.rd <= 1'h0;
        #1 d = busRdata;
    endtask : rd
    // bounded waits; running out counts as a mismatch and ends the run
    task automatic waitStart(input int bound, output int lat);
        lat = 0;
        do begin
            @(posedge clk);
            #1 lat++;
            if (lat > bound) begin
                check("start wait", 0, 1);
                tally_and_finish();
            end
        end while (frameStartPulse !== 1'h1);
    endtask : waitStart
    task automatic waitFor(input bit idle);
        int k;
        k = 0;
        while (idle ? acquisitionActive !== 1'h0
                    : waitingForTrigger !== 1'h1) begin
            @(posedge clk);
            #1 k++;
            if (k > 2000) begin
                check("ready wait", 0, 1);
                tally_and_finish();
            end
        end
    endtask : waitFor
    task automatic expoLen(output int len);
        len = 0;
        while (exposureActive === 1'h1) begin
            len++;
            if (len > 500) begin
                check("exposure wait", 0, 1);
                tally_and_finish();
            end
            @(posedge clk);
            #1;
        end
    endtask : expoLen
    function automatic logic [31:0] ctl(input logic [2:0] s,
        input logic [1:0] e, input logic w, input logic u);
        return {23'h0, u, 1'h0, w, e, s, 1'h1};
    endfunction : ctl
    // readout kept long enough that a busy check never lands on its edge
    task automatic setup(input logic [31:0] c, input logic [31:0] e);
        wr(`EST_OFF_CTRL, c);
        wr(`EST_OFF_EXPOSURE, e);
        wr(`EST_OFF_READOUT, 32'h8);
        wr(`EST_OFF_CMD, 32'h1);
        #1 check("acq on", 1, acquisitionActive);
    endtask : setup
    task automatic stopAcq();
        wr(`EST_OFF_CMD, 32'h2);
        waitFor(1'h1);
    endtask : stopAcq
    ////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        logic [7:0] offs [6];
        logic [31:0] exps [6];
        logic [31:0] d;
        offs = '{`EST_OFF_EXPOSURE, `EST_OFF_PERIOD, `EST_OFF_MIN_PERIOD,
                 `EST_OFF_READOUT, `EST_OFF_STATUS, 8'h3C};
        exps = '{`EST_RST_EXPOSURE, `EST_RST_PERIOD, `EST_RST_MIN_PERIOD,
                 `EST_RST_READOUT, 32'h0, 32'h0};
        foreach (offs[i]) begin
            rd(offs[i], d);
            check("reset value", exps[i], d);
        end
        check("idle outputs", 0, {exposureActive, frameStartPulse,
            waitingForTrigger, acquisitionActive});
        $display("test regs done");
    endtask : t_regs
    task automatic t_soft();
        setup(ctl(`EST_SRC_SOFTWARE, `EST_EDGE_RISE, 1'h0, 1'h0), 32'h6);
        check("waiting", 1, waitingForTrigger);
        wr(`EST_OFF_CMD, 32'h4);
        #1 check("sw start", 1, frameStartPulse);
        expoLen(n);
        check("sw exposure", 6, n);
        l0 = starts;
        wr(`EST_OFF_CMD, 32'h4);
        #1 check("busy", 0, waitingForTrigger);
        waitFor(1'h0);
        check("sw ignored", l0, starts);
        wr(`EST_OFF_CMD, 32'h4);
        #1 check("sw again", 1, frameStartPulse);
        stopAcq();
        $display("test soft done");
    endtask : t_soft
    task automatic t_edges();
        for (int e = 0; e < 2; e++) begin
            setup(ctl(`EST_SRC_LINE, e[1:0], 1'h0, 1'h0), 32'h4);
            l0 = starts;
            u_est_trigger_source.setExt(1'h1);
            repeat (15) @(posedge clk);
            check("rise half", l0 + (e == 0), starts);
            u_est_trigger_source.setExt(1'h0);
            repeat (15) @(posedge clk);
            check("fall half", l0 + 1, starts);
            stopAcq();
        end
        setup(ctl(`EST_SRC_LINE, `EST_EDGE_BOTH, 1'h0, 1'h0), 32'h4);
        l0 = starts;
        u_est_trigger_source.squareExt(20, 2);
        repeat (20) @(posedge clk);
        check("both edges", l0 + 4, starts);
        stopAcq();
        $display("test edges done");
    endtask : t_edges
    task automatic t_width();
        setup(ctl(`EST_SRC_LINE, `EST_EDGE_RISE, 1'h1, 1'h0), 32'h4);
        fork
            begin
                u_est_trigger_source.setExt(1'h1);
                repeat (11) @(posedge clk);
                u_est_trigger_source.setExt(1'h0);
            end
            begin
                waitStart(20, l0);
                expoLen(n);
            end
        join
        check("line width", 1, n inside {[11:13]});
        stopAcq();
        $display("test width done");
    endtask : t_width
    task automatic t_timer();
        setup(ctl(`EST_SRC_LINE, `EST_EDGE_RISE, 1'h0, 1'h0), 32'h4);
        u_est_trigger_source.setExt(1'h1);
        waitStart(20, l0);
        waitFor(1'h0);
        u_est_trigger_source.setExt(1'h0);
        stopAcq();
        wr(`EST_OFF_TIMER_DELAY, 32'h14);
        wr(`EST_OFF_TIMER_DUR, 32'h7);
        setup(ctl(`EST_SRC_TIMER, `EST_EDGE_RISE, 1'h1, 1'h0), 32'h4);
        u_est_trigger_source.setExt(1'h1);
        waitStart(60, l1);
        check("timer delay", 1, l1 inside {[l0 + 20:l0 + 22]});
        expoLen(n);
        check("timer duration", 7, n);
        waitFor(1'h0);
        u_est_trigger_source.setExt(1'h0);
        stopAcq();
        $display("test timer done");
    endtask : t_timer
    task automatic t_grab();
        setup(ctl(`EST_SRC_GRABBER, `EST_EDGE_RISE, 1'h0, 1'h0), 32'h14);
        l0 = starts;
        u_est_trigger_source.pulseGrab(3);
        repeat (8) @(posedge clk);
        u_est_trigger_source.pulseGrab(3);
        waitFor(1'h0);
        check("grabber overlap", l0 + 1, starts);
        u_est_trigger_source.pulseGrab(3);
        repeat (10) @(posedge clk);
        check("grabber start", l0 + 2, starts);
        stopAcq();
        $display("test grab done");
    endtask : t_grab
    task automatic t_user();
        setup(ctl(`EST_SRC_USEROUT, `EST_EDGE_RISE, 1'h1, 1'h0), 32'h4);
        fork
            begin
                wr(`EST_OFF_CTRL, ctl(`EST_SRC_USEROUT, 2'h0, 1'h1, 1'h1));
                repeat (8) @(posedge clk);
                wr(`EST_OFF_CTRL, ctl(`EST_SRC_USEROUT, 2'h0, 1'h1, 1'h0));
            end
            begin
                waitStart(10, l0);
                expoLen(n);
            end
        join
        check("user bit start", 1, l0 <= 5);
        check("user bit width", 1, n inside {[9:11]});
        stopAcq();
        $display("test user done");
    endtask : t_user
    task automatic t_free();
        wr(`EST_OFF_PERIOD, 32'h14);
        wr(`EST_OFF_MIN_PERIOD, 32'h1E);
        setup(32'h0, 32'h3);
        waitStart(40, l0);
        expoLen(n);
        check("free exposure", 3, n);
        waitStart(40, l0);
        check("clamped gap", 30, 3 + l0);
        wr(`EST_OFF_MIN_PERIOD, 32'hA);
        waitStart(40, l0);
        waitStart(40, l1);
        check("programmed gap", 20, l1);
        waitStart(40, l0);
        wr(`EST_OFF_CMD, 32'h2);
        #1 check("frame finishes", 1, exposureActive);
        waitFor(1'h1);
        l0 = starts;
        repeat (40) @(posedge clk);
        check("no frames after stop", l0, starts);
        $display("test free done");
    endtask : t_free
    task automatic t_misc();
        logic [31:0] d;
        wr(`EST_OFF_TIMER_DUR, 32'hA5C3_0F96);
        rd(`EST_OFF_TIMER_DUR, d);
        check("wide data", 32'hA5C3_0F96, d);
        rd(8'hC4, d);
        check("unmapped high", 0, d);
        setup(ctl(`EST_SRC_TIMER, `EST_EDGE_RISE, 1'h1, 1'h0)
              | (32'h1 << `EST_CTRL_TLEVEL), 32'h4);
        fork
            begin
                u_est_trigger_source.setExt(1'h1);
                repeat (30) @(posedge clk);
                u_est_trigger_source.setExt(1'h0);
            end
            begin
                waitStart(40, l0);
                expoLen(n);
            end
        join
        check("level timer", 1, n inside {[9:11]});
        stopAcq();
        // enable low freezes the frame and drops bus strobes
        setup(ctl(`EST_SRC_SOFTWARE, `EST_EDGE_RISE, 1'h0, 1'h0), 32'h6);
        rd(`EST_OFF_STATUS, d);
        check("status wait", 32'h3, d);
        wr(`EST_OFF_CMD, 32'h4);
        clkEn <= 1'h0;
        wr(`EST_OFF_EXPOSURE, 32'h9);
        #1 check("frozen pulse", 1, frameStartPulse);
        @(posedge clk);
        clkEn <= 1'h1;
        expoLen(n);
        check("frozen exposure", 6, n);
        rd(`EST_OFF_EXPOSURE, d);
        check("frozen write", 6, d);
        // reset in mid-frame, during readout
        @(posedge clk);
        resetn <= 1'h0;
        repeat (2) @(posedge clk);
        resetn <= 1'h1;
        #1 check("reset outputs", 0, {exposureActive, frameStartPulse,
            waitingForTrigger, acquisitionActive});
        rd(`EST_OFF_EXPOSURE, d);
        check("reset exposure", `EST_RST_EXPOSURE, d);
        rd(`EST_OFF_TIMER_DUR, d);
        check("reset duration", 0, d);
        $display("test misc done");
    endtask : t_misc
    ////////////////////////////////////////////////////////////////////////
    initial begin
        resetn = 1'h0;
        clkEn = 1'h1;
        busReq = '0;
        repeat (2) @(posedge clk);
        resetn <= 1'h1;
        t_regs();
        t_soft();
        t_edges();
        t_width();
        t_timer();
        t_grab();
        t_user();
        t_free();
        t_misc();
        tally_and_finish();
    end
endmodule : est_trigger_ctrl_test
